// ==== core/frs_pkg.sv ====
// Purpose: shared constants and types for the flash rewrite sequencer
// Assumes: one 125 MHz clock, plain register port
// Notes:   register offsets, control/suspend/status fields, the control reset and timing counts live here
package frs_pkg;
   // register word addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_SUSP   = 4'h1;
   localparam logic [3:0] ADDR_STAT   = 4'h2;
   localparam logic [3:0] ADDR_CMD    = 4'h3;
   localparam logic [3:0] ADDR_LOCK   = 4'h4;
   // control register fields
   localparam int CTRL_REWR_EN    = 0;
   localparam int CTRL_LOCK_DIS   = 1;
   localparam int CTRL_MODE_SEL   = 2;
   localparam int CTRL_SUSP_EN    = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // suspend register fields
   localparam int SUSP_REQ        = 0;
   // status register fields
   localparam int STAT_READY      = 0;
   localparam int STAT_ERS_SUSP   = 1;
   localparam int STAT_PRG_SUSP   = 2;
   localparam int STAT_REFUSED    = 3;
   localparam int STAT_ABORTED    = 4;
   localparam int STAT_READ_ARRAY = 5;
   // timing
   localparam int CLK_MHZ          = 125;
   localparam int SUSP_DELAY_NS    = 20000;
   localparam int SUSP_DELAY_CYC   = (SUSP_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int OP_TIME_CYC      = 100000;
   localparam int NUM_BLOCKS       = 8;
   // command codes
   typedef enum logic [2:0] {
      FRS_CMD_READ_ARRAY = 3'h0,
      FRS_CMD_CLR_STAT   = 3'h1,
      FRS_CMD_PROGRAM    = 3'h2,
      FRS_CMD_ERASE      = 3'h3,
      FRS_CMD_LOCK_PRG   = 3'h4,
      FRS_CMD_READ_LOCK  = 3'h5,
      FRS_CMD_BLANK      = 3'h6
   } frs_cmd_t;
   // register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } frs_bus_t;
   // forced-stop interrupt sources
   typedef struct packed {
      logic nmi;
      logic wdt;
      logic osc;
      logic vdet;
   } frs_force_t;
endpackage : frs_pkg

// ==== core/frs_delay.sv ====
// Purpose: suspend accept delay counter
// Assumes: start is a level held while waiting
// Notes:   done rises after CYCLES clocks of continuous start
`timescale 1ns/1ps
module frs_delay #(
   parameter int CYCLES = 2500
) (
   // clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RST,
   // control
   input  wire logic i_start,
   output logic      o_done
);
   logic [31:0] cnt_ff;

   // count up while requested, clear otherwise so each request waits in full
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         cnt_ff <= 32'h0;
      end else if (!i_start) begin
         cnt_ff <= 32'h0;
      end else if (cnt_ff < 32'(CYCLES)) begin
         cnt_ff <= cnt_ff + 32'h1;
      end
   end

   assign o_done = i_start && (cnt_ff >= 32'(CYCLES));
endmodule : frs_delay

// ==== core/frs_seq.sv ====
// Purpose: flash self-rewrite sequencer with suspend, lock bits and cpu stall
// Assumes: cpu drives the register port; flash array timing is a counter
// Notes:   long counts are parameters so simulation can shorten them
// Function
// RL1: ram-resident suspend accepted only after accept delay from request bit set.
// RL2: software touches flash in suspend only after suspend status shows acceptance.
// RL3: clearing the suspend request bit restarts the suspended operation.
// RL4: ram-resident interrupt routine requests suspend only while operation runs.
// RL5: rom-resident mode is mode select 1 with rewrite enable 1.
// RL6: rom-resident mode stalls the cpu during program or erase.
// RL7: rom-resident, suspend enabled: interrupt accepted after delay, enters suspend.
// RL8: rom-resident, suspend disabled: interrupt held pending until operation completes.
// RL9: forced-stop interrupts abort the operation at once.
// RL10: after an abort software re-runs and verifies the erase.
// RL11: rom-resident mode stops the watchdog during program or erase.
// RL12: watchdog keeps counting during suspend.
// RL13: software avoids rom-resident mode with watchdog source protection on.
// RL14: rom-resident mode leaves flash in read array after every command.
// RL15: software sets cpu clock to 16 MHz or less first.
// RL16: software sets the flash wait state bit first.
// RL17: lock enabled and lock bit 0 refuses program and erase.
// RL18: a lock bit clears only by lock bit program on that block.
// RL19: erase with lock disabled erases anyway and sets lock bit to 1.
// RL20: read lock bit status returns the block lock bit.
// RL21: ram-resident mode is mode select 0 with rewrite enable 1.
// RL22: accept delay is a parameterised counter started on request during operation.
`timescale 1ns/1ps
module frs_seq #(
   parameter int SUSP_CYC = frs_pkg::SUSP_DELAY_CYC,
   parameter int OP_CYC   = frs_pkg::OP_TIME_CYC,
   parameter int NBLK     = frs_pkg::NUM_BLOCKS
) (
   // clock and reset
   input  wire logic               I_CLK,
   input  wire logic               I_RST,
   // register port
   input  wire frs_pkg::frs_bus_t  I_BUS,
   output logic [7:0]              O_RDATA,
   // interrupt sources
   input  wire logic               I_MASK_IRQ,
   input  wire frs_pkg::frs_force_t I_FORCE_IRQ,
   // cpu side
   output logic                    O_CPU_STALL,
   output logic                    O_IRQ_GRANT,
   output logic                    O_FORCE_GRANT,
   output logic                    O_WDT_RUN
);
   typedef enum {ST_IDLE, ST_BUSY, ST_SUSP} frs_state_t;

   frs_state_t       state_ff;
   logic [7:0]       ctrl_ff;
   logic             susp_req_ff;
   logic             is_erase_ff;
   logic             refused_ff;
   logic             aborted_ff;
   logic             read_array_ff;
   logic [31:0]      op_cnt_ff;
   logic [NBLK-1:0]  lock_ff;
   logic [2:0]       blk_ff;
   logic             lock_prg_ff;
   logic [7:0]       rdata_ff;
   logic             lock_rd_ff;

   logic rewr_en;
   logic ew1_mode;
   logic ew0_mode;
   logic susp_en;
   logic lock_dis;
   logic cmd_wr;
   logic [2:0] cmd_code;
   logic [2:0] cmd_blk;
   logic blk_ok;
   logic start_op;
   logic force_any;
   logic delay_start;
   logic delay_done;
   logic op_done;

   // mode decode
   assign rewr_en  = ctrl_ff[frs_pkg::CTRL_REWR_EN];
   assign ew1_mode = rewr_en && ctrl_ff[frs_pkg::CTRL_MODE_SEL];   // [RL5]
   assign ew0_mode = rewr_en && !ctrl_ff[frs_pkg::CTRL_MODE_SEL];  // [RL21]
   assign susp_en  = ctrl_ff[frs_pkg::CTRL_SUSP_EN];
   assign lock_dis = ctrl_ff[frs_pkg::CTRL_LOCK_DIS];
   assign force_any = |I_FORCE_IRQ;

   // command word: low 3 bits code, next 3 bits block
   assign cmd_wr   = I_BUS.wr && (I_BUS.addr == frs_pkg::ADDR_CMD) && rewr_en;
   assign cmd_code = I_BUS.wdata[2:0];
   assign cmd_blk  = I_BUS.wdata[5:3];
   // lock check; out-of-range blocks are never writable
   assign blk_ok   = (32'(cmd_blk) < 32'(NBLK)) &&
                     (lock_dis || lock_ff[cmd_blk]);                // [RL17]
   assign start_op = cmd_wr && (state_ff == ST_IDLE) &&
                     (cmd_code == frs_pkg::FRS_CMD_PROGRAM ||
                      cmd_code == frs_pkg::FRS_CMD_ERASE ||
                      cmd_code == frs_pkg::FRS_CMD_LOCK_PRG) && blk_ok;
   assign op_done  = (state_ff == ST_BUSY) && (op_cnt_ff >= 32'(OP_CYC - 1));

   // delay runs on a request raised while busy: bit in ram mode, irq in rom mode with suspend enabled
   assign delay_start = (state_ff == ST_BUSY) && !force_any &&
                        ((ew0_mode && susp_req_ff) ||
                         (ew1_mode && susp_en && I_MASK_IRQ));     // [RL22]

   frs_delay #(
      .CYCLES (SUSP_CYC)
   ) u_delay (
      .I_CLK   (I_CLK),
      .I_RST   (I_RST),
      .i_start (delay_start),
      .o_done  (delay_done)
   );

   // control register
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_ff <= frs_pkg::CTRL_RESET;
      end else if (I_BUS.wr && I_BUS.addr == frs_pkg::ADDR_CTRL) begin
         ctrl_ff <= {4'h0, I_BUS.wdata[3:0]};
      end
   end

   // suspend request bit; rom-mode irq acceptance also sets it
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         susp_req_ff <= 1'b0;
      end else if (ew1_mode && delay_done) begin
         susp_req_ff <= 1'b1;                                       // [RL7]
      end else if (I_BUS.wr && I_BUS.addr == frs_pkg::ADDR_SUSP) begin
         susp_req_ff <= I_BUS.wdata[frs_pkg::SUSP_REQ];
      end
   end

   // operation state machine
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_op && !force_any) begin
                  state_ff <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (force_any) begin
                  state_ff <= ST_IDLE;                              // [RL9]
               end else if (delay_done) begin
                  state_ff <= ST_SUSP;                              // [RL1] [RL7]
               end else if (op_done) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_SUSP: begin
               if (force_any) begin
                  state_ff <= ST_IDLE;
               end else if (!susp_req_ff) begin
                  state_ff <= ST_BUSY;                              // [RL3]
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // operation progress; held in suspend so a restart resumes
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         op_cnt_ff <= 32'h0;
      end else if (start_op) begin
         op_cnt_ff <= 32'h0;
      end else if (state_ff == ST_BUSY && !delay_done) begin
         op_cnt_ff <= op_cnt_ff + 32'h1;
      end
   end

   // remember which operation and block is in flight
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         is_erase_ff <= 1'b0;
         lock_prg_ff <= 1'b0;
         blk_ff      <= 3'h0;
      end else if (start_op) begin
         is_erase_ff <= (cmd_code == frs_pkg::FRS_CMD_ERASE);
         lock_prg_ff <= (cmd_code == frs_pkg::FRS_CMD_LOCK_PRG);
         blk_ff      <= cmd_blk;
      end
   end

   // lock bits: nonvolatile array modeled as unlocked at reset
   genvar gi;
   generate
      for (gi = 0; gi < NBLK; gi++) begin : g_lock
         always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
               lock_ff[gi] <= 1'b1;
            end else if (op_done && 32'(blk_ff) == gi) begin
               if (lock_prg_ff) begin
                  lock_ff[gi] <= 1'b0;                              // [RL18]
               end else if (is_erase_ff && lock_dis) begin
                  lock_ff[gi] <= 1'b1;                              // [RL19]
               end
            end
         end
      end
   endgenerate

   // status flags: refused and aborted are sticky, cleared by clear status
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         refused_ff <= 1'b0;
         aborted_ff <= 1'b0;
      end else begin
         if (state_ff != ST_IDLE && force_any) begin
            aborted_ff <= 1'b1;                                     // [RL9]
         end else if (cmd_wr && cmd_code == frs_pkg::FRS_CMD_CLR_STAT) begin
            aborted_ff <= 1'b0;
         end
         if (cmd_wr && state_ff == ST_IDLE && !blk_ok &&
             (cmd_code == frs_pkg::FRS_CMD_PROGRAM || cmd_code == frs_pkg::FRS_CMD_ERASE)) begin
            refused_ff <= 1'b1;                                     // [RL17]
         end else if (cmd_wr && cmd_code == frs_pkg::FRS_CMD_CLR_STAT) begin
            refused_ff <= 1'b0;
         end
      end
   end

   // array read mode: rom mode always returns to read array
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         read_array_ff <= 1'b1;
         lock_rd_ff    <= 1'b0;
      end else if (cmd_wr) begin
         read_array_ff <= ew1_mode ||
                          cmd_code == frs_pkg::FRS_CMD_READ_ARRAY ||
                          cmd_code == frs_pkg::FRS_CMD_CLR_STAT;    // [RL14]
         if (cmd_code == frs_pkg::FRS_CMD_READ_LOCK && 32'(cmd_blk) < 32'(NBLK)) begin
            lock_rd_ff <= lock_ff[cmd_blk];                         // [RL20]
         end
      end
   end

   // read data one cycle after the read strobe, zero otherwise
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdata_ff <= 8'h00;
      end else if (I_BUS.rd) begin
         case (I_BUS.addr)
            frs_pkg::ADDR_CTRL: rdata_ff <= ctrl_ff;
            frs_pkg::ADDR_SUSP: rdata_ff <= {7'h00, susp_req_ff};
            frs_pkg::ADDR_STAT: rdata_ff <= {2'h0, read_array_ff, aborted_ff, refused_ff,
                                             state_ff == ST_SUSP && !is_erase_ff,
                                             state_ff == ST_SUSP && is_erase_ff,
                                             state_ff == ST_IDLE};
            frs_pkg::ADDR_LOCK: rdata_ff <= {7'h00, lock_rd_ff};
            default:            rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end
   assign O_RDATA = rdata_ff;

   // cpu and interrupt outputs
   assign O_CPU_STALL   = ew1_mode && (state_ff == ST_BUSY);        // [RL6]
   // pending in rom mode while busy; in suspend the irq is serviced
   assign O_IRQ_GRANT   = I_MASK_IRQ && !(ew1_mode && state_ff == ST_BUSY); // [RL8]
   assign O_FORCE_GRANT = force_any;
   // watchdog halted only while rom-mode operation actually runs
   assign O_WDT_RUN     = !(ew1_mode && state_ff == ST_BUSY);       // [RL11] [RL12]

   // cycles the current suspend request has stood; cross-checks the delay counter
   logic [31:0] req_age_ff;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         req_age_ff <= 32'h0;
      end else if (!delay_start) begin
         req_age_ff <= 32'h0;
      end else if (req_age_ff < 32'(SUSP_CYC)) begin
         req_age_ff <= req_age_ff + 32'h1;
      end
   end

   // assertions
   a_stall_rom_busy: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL6] [RL11]
      (ew1_mode && state_ff == ST_BUSY) |-> O_CPU_STALL && !O_WDT_RUN)
      else $error("cpu not stalled in rom-mode operation");
   a_wdt_in_susp: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL12]
      (state_ff == ST_SUSP) |-> O_WDT_RUN)
      else $error("watchdog stopped during suspend");
   a_force_abort: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL9]
      (state_ff != ST_IDLE && force_any) |=> state_ff == ST_IDLE && aborted_ff)
      else $error("forced interrupt did not abort");

   // a request that has just been raised
   sequence s_req_rise;
      !delay_start ##1 delay_start;
   endsequence
   // rom-mode irq reaching the end of its accept delay
   sequence s_rom_accept;
      ew1_mode && state_ff == ST_BUSY && delay_done && !force_any;
   endsequence
   // suspended with the request bit raised by hardware
   sequence s_rom_susp;
      state_ff == ST_SUSP && susp_req_ff;
   endsequence

   a_no_early_susp: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL1]
      s_req_rise |-> !delay_done)
      else $error("suspend accepted too early");
   a_accept_delay: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL1] [RL22]
      delay_done |-> req_age_ff >= 32'(SUSP_CYC))
      else $error("suspend accepted before the full delay");
   a_ram_no_req: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL1]
      (ew0_mode && state_ff == ST_BUSY && !susp_req_ff) |=> state_ff != ST_SUSP)
      else $error("ram-mode suspend without request bit");
   a_rom_susp: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL7]
      s_rom_accept |=> s_rom_susp)
      else $error("rom-mode irq did not enter suspend");
   a_restart: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL3]
      (state_ff == ST_SUSP && !susp_req_ff && !force_any) |=> state_ff == ST_BUSY)
      else $error("no restart on request clear");
   // progress must be frozen in suspend so a restart resumes where it stopped
   a_susp_hold: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL3]
      (state_ff == ST_SUSP) |=> $stable(op_cnt_ff))
      else $error("operation progressed while suspended");
   a_irq_pending: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL8]
      (ew1_mode && !susp_en && state_ff == ST_BUSY) |-> !O_IRQ_GRANT)
      else $error("irq serviced during rom-mode operation");
   a_lock_refuse: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL17]
      (cmd_wr && state_ff == ST_IDLE && !lock_dis && !force_any && !lock_ff[cmd_blk] &&
       (cmd_code == frs_pkg::FRS_CMD_ERASE || cmd_code == frs_pkg::FRS_CMD_PROGRAM))
      |=> state_ff == ST_IDLE)
      else $error("locked block started");
   a_read_array: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL14]
      (cmd_wr && ew1_mode) |=> read_array_ff)
      else $error("rom mode left read array");
   a_lock_stable: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL18]
      (!op_done) |=> $stable(lock_ff))
      else $error("lock bits changed without a command");
   a_lock_clear: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL18]
      (op_done && lock_prg_ff) |=> !lock_ff[blk_ff])
      else $error("lock bit program did not lock the block");
   a_lock_set: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL19]
      (op_done && is_erase_ff && lock_dis) |=> lock_ff[blk_ff])
      else $error("erase with lock disabled left block locked");
   // read data stands for one cycle only, so stale data cannot be mistaken
   a_rdata_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_BUS.rd |=> O_RDATA == 8'h00)
      else $error("read data present without a read");
endmodule : frs_seq

// ==== bench/frs_cpu_model.sv ====
// Purpose: cpu model that drives the register port of the sequencer
// Assumes: caller is just past a rising edge when a task starts
// Notes:   an idle cycle follows each strobe so no strobe is assigned twice
`timescale 1ns/1ps
module frs_cpu_model (
   // clock
   input  wire logic         i_clk,
   // register port
   input  wire logic [7:0]   i_rdata,
   output frs_pkg::frs_bus_t o_bus
);
   initial o_bus = '0;

   // write strobe; idle fields show inverted values so stale data never looks valid
   task automatic bwr(input logic [3:0] a, input logic [7:0] d);
      o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge i_clk);
   endtask : bwr

   // read strobe; data stands only in the following cycle, so it is taken there
   task automatic brd(input logic [3:0] a, output logic [7:0] d);
      o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      #1;
      d = i_rdata;
      @(posedge i_clk);
   endtask : brd
   // clock divider and wait-state setup are assumed done before rewrite
   // rom-resident mode is used only with watchdog source protection off
endmodule : frs_cpu_model

// ==== bench/flash_rewrite_suspend_lock_tb_top.sv ====
// Purpose: self-checking bench for the flash rewrite sequencer
// Assumes: short accept delay and operation time for simulation
// Notes:   reads note expectations in a queue; a monitor pops and compares
`timescale 1ns/1ps
module flash_rewrite_suspend_lock_tb_top;
   localparam int SC = 5;
   localparam int OC = 40;
   logic                clk, rst, irq, stall, igr, fgr, wdt, rd_q;
   logic [7:0]          rdata, d;
   logic [2:0]          blk;
   logic [15:0]         e;
   logic [15:0]         expq[$];
   logic [2:0]          op[3];
   logic [7:0]          sb[3];
   frs_pkg::frs_bus_t   bus;
   frs_pkg::frs_force_t frc;
   int                  errors, cmp_count, seed, i;

   // free-running clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   frs_seq #(.SUSP_CYC(SC), .OP_CYC(OC)) u_frs_seq (
      .I_CLK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata), .I_MASK_IRQ(irq),
      .I_FORCE_IRQ(frc), .O_CPU_STALL(stall), .O_IRQ_GRANT(igr),
      .O_FORCE_GRANT(fgr), .O_WDT_RUN(wdt));
   frs_cpu_model u_frs_cpu_model (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

   task automatic conclude;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic chk_lvl(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_lvl

   task automatic chk_rd(input logic [7:0] got, input logic [7:0] m, input logic [7:0] x);
      cmp_count++;
      if ((got & m) !== x) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got & m, x);
      end
   endtask : chk_rd

   // monitor: read data stands the cycle after the strobe, sampled at its closing edge
   always @(posedge clk) begin
      if (rd_q) begin
         e = expq.pop_front();
         chk_rd(rdata, e[15:8], e[7:0]);
      end
      rd_q <= bus.rd;
   end

   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
      expq.push_back({m, x});
      u_frs_cpu_model.brd(a, d);
   endtask : rd

   task automatic stat(input logic [7:0] m, input logic [7:0] x);
      rd(frs_pkg::ADDR_STAT, m, x);
   endtask : stat

   task automatic cmd(input frs_pkg::frs_cmd_t c, input logic [2:0] b);
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CMD, {2'b00, b, c});
   endtask : cmd

   // bounded poll of the ready bit; running out ends the run
   task automatic wait_ready;
      for (int k = 0; k < 400; k++) begin
         stat(8'h00, 8'h00);
         if (d[0] === 1'b1)
            return;
      end
      errors++;
      conclude();
   endtask : wait_ready

   initial begin
      seed = 32'hc015;
      errors = 0;
      cmp_count = 0;
      irq = 1'b0;
      frc = '0;
      rst = 1'b1;
      op = '{frs_pkg::FRS_CMD_PROGRAM, frs_pkg::FRS_CMD_ERASE, frs_pkg::FRS_CMD_LOCK_PRG};
      sb = '{8'h04, 8'h02, 8'h04};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values, unmapped read, command ignored while rewrite disabled
      rd(frs_pkg::ADDR_CTRL, 8'hFF, frs_pkg::CTRL_RESET);
      rd(4'hF, 8'hFF, 8'h00);
      cmd(frs_pkg::FRS_CMD_PROGRAM, 3'h1);
      stat(8'h01, 8'h01);
      // ram-resident: each suspendable operation, suspend early, then restart
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CTRL, 8'h01);
      for (i = 0; i < 3; i++) begin
         cmd(frs_pkg::frs_cmd_t'(op[i]), (i == 2) ? 3'h2 : 3'h1);
         chk_lvl(stall, 1'b0);
         stat(8'h27, 8'h00);
         u_frs_cpu_model.bwr(frs_pkg::ADDR_SUSP, 8'h01);
         stat(8'h06, 8'h00);
         repeat (SC) @(posedge clk);
         stat(8'h06, sb[i]);
         u_frs_cpu_model.bwr(frs_pkg::ADDR_SUSP, 8'h00);
         stat(8'h07, 8'h00);
         wait_ready();
      end
      // lock bits: block 2 locked, block 1 untouched by lock program
      cmd(frs_pkg::FRS_CMD_READ_LOCK, 3'h2);
      rd(frs_pkg::ADDR_LOCK, 8'h01, 8'h00);
      cmd(frs_pkg::FRS_CMD_READ_LOCK, 3'h1);
      rd(frs_pkg::ADDR_LOCK, 8'h01, 8'h01);
      cmd(frs_pkg::FRS_CMD_PROGRAM, 3'h2);
      stat(8'h09, 8'h09);
      cmd(frs_pkg::FRS_CMD_CLR_STAT, 3'h0);
      stat(8'h08, 8'h00);
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CTRL, 8'h03);
      cmd(frs_pkg::FRS_CMD_ERASE, 3'h2);
      stat(8'h09, 8'h00);
      wait_ready();
      cmd(frs_pkg::FRS_CMD_READ_LOCK, 3'h2);
      rd(frs_pkg::ADDR_LOCK, 8'h01, 8'h01);
      // ram mode: read array returns to array reads, blank check does not
      cmd(frs_pkg::FRS_CMD_READ_ARRAY, 3'h0);
      stat(8'h20, 8'h20);
      cmd(frs_pkg::FRS_CMD_BLANK, 3'h0);
      stat(8'h21, 8'h01);
      // rom-resident, suspend disabled: cpu held, irq waits past the accept delay
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CTRL, 8'h05);
      cmd(frs_pkg::FRS_CMD_PROGRAM, 3'h3);
      irq <= 1'b1;
      @(posedge clk);
      #1;
      chk_lvl(stall, 1'b1);
      chk_lvl(wdt, 1'b0);
      chk_lvl(igr, 1'b0);
      repeat (2 * SC) @(posedge clk);
      stat(8'h06, 8'h00);
      wait_ready();
      chk_lvl(igr, 1'b1);
      stat(8'h20, 8'h20);
      // rom-resident, suspend enabled: irq accepted only after the delay
      irq <= 1'b0;
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CTRL, 8'h0D);
      cmd(frs_pkg::FRS_CMD_ERASE, 3'h3);
      irq <= 1'b1;
      repeat (SC - 2) @(posedge clk);
      #1;
      chk_lvl(igr, 1'b0);
      repeat (6) @(posedge clk);
      #1;
      chk_lvl(igr, 1'b1);
      chk_lvl(stall, 1'b0);
      chk_lvl(wdt, 1'b1);
      stat(8'h06, 8'h02);
      irq <= 1'b0;
      u_frs_cpu_model.bwr(frs_pkg::ADDR_SUSP, 8'h00);
      #1;
      chk_lvl(stall, 1'b1);
      wait_ready();
      cmd(frs_pkg::FRS_CMD_BLANK, 3'h0);
      stat(8'h20, 8'h20);
      // forced stop from every source aborts at once, then erase is re-run
      u_frs_cpu_model.bwr(frs_pkg::ADDR_CTRL, 8'h01);
      for (i = 0; i < 4; i++) begin
         blk = 3'($random(seed));
         cmd(frs_pkg::FRS_CMD_PROGRAM, blk);
         frc <= frs_pkg::frs_force_t'(4'b0001 << i);
         @(posedge clk);
         #1;
         chk_lvl(fgr, 1'b1);
         stat(8'h11, 8'h11);
         frc <= '0;
         cmd(frs_pkg::FRS_CMD_CLR_STAT, 3'h0);
         cmd(frs_pkg::FRS_CMD_ERASE, blk);
         wait_ready();
         stat(8'h18, 8'h00);
      end
      // let the monitor compare the last read before the verdict
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule : flash_rewrite_suspend_lock_tb_top
